// >>> logic/pcp_pkg.sv
// constants and types shared by both ends of the control-pin link
package pcp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_MIN_NS    = 1000;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCK_MAX_KHZ   = 2500;
  localparam int TCK_PER_NS    = 1000000 / TCK_MAX_KHZ;
  localparam int TCK_HALF_CYC  = (TCK_PER_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MG_MAX_KHZ    = 25000;
  localparam int MG_PER_NS     = 1000000 / MG_MAX_KHZ;
  localparam int MG_HALF_CYC   = (MG_PER_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_KHZ       = 25000;
  localparam int REF_HALF_CYC  = 1000000 / REF_KHZ / 2 / CLK_PERIOD_NS;

  // ----------------------------------------
  // management frame and registers
  // ----------------------------------------
  localparam int         MG_FRAME_BITS = 12;
  localparam int         MG_HDR_BITS   = 4;
  localparam logic [3:0] MG_LAST_BIT   = 4'hb;
  localparam logic [3:0] MG_ADDR_BIT   = 4'h3;
  localparam logic [1:0] MG_ADDR_CTRL  = 2'h0;
  localparam logic [1:0] MG_ADDR_STAT  = 2'h1;
  localparam int         CTRL_IRQ_MODE = 0;
  localparam int         CTRL_IRQ_EN   = 1;
  localparam int         STAT_PEND     = 0;
  localparam int         STAT_ASLEEP   = 1;
  localparam logic [7:0] CTRL_RST      = 8'h00;

  // ----------------------------------------
  // test access port
  // ----------------------------------------
  localparam int          IR_W       = 2;
  localparam logic [1:0]  IR_IDCODE  = 2'h1;
  localparam logic [1:0]  IR_BYPASS  = 2'h3;
  localparam logic [1:0]  IR_CAPTURE = 2'h1;
  localparam int          DR_W       = 32;
  // arbitrary value, bit 0 set as an identity register needs
  localparam logic [31:0] ID_VALUE   = 32'h1234_5001;

  typedef enum logic [3:0] {
    PCP_TLR   = 4'h0, PCP_RTI   = 4'h1, PCP_SELDR = 4'h3, PCP_CAPDR = 4'h2,
    PCP_SHDR  = 4'h6, PCP_EX1DR = 4'h7, PCP_PSDR  = 4'h5, PCP_EX2DR = 4'h4,
    PCP_UPDR  = 4'hc, PCP_SELIR = 4'hd, PCP_CAPIR = 4'hf, PCP_SHIR  = 4'he,
    PCP_EX1IR = 4'ha, PCP_PSIR  = 4'hb, PCP_EX2IR = 4'h9, PCP_UPIR  = 4'h8
  } pcp_tap_t;

endpackage

// >>> logic/pcp_link_if.sv
// pins between the transceiver control logic and its host / tester
`timescale 1ns/100ps
interface pcp_link_if;
  logic hard_rst_n;
  logic ref_osc_input;
  logic host_pin_o;
  logic host_pin_oe_n;
  logic dev_pin_o;
  logic dev_pin_oe_n;
  logic irq_or_sleep_pin;
  logic mgmt_clk;
  logic mgmt_wdata;
  logic mgmt_rdata;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic scan_port_init_low;

  // open-drain wire with pull-up
  assign irq_or_sleep_pin = ((!dev_pin_oe_n && !dev_pin_o) ||
                             (!host_pin_oe_n && !host_pin_o)) ? 1'b0 : 1'b1;

  modport dev (
    input  hard_rst_n, irq_or_sleep_pin, mgmt_clk, mgmt_wdata,
    input  tck, tms, tdi, scan_port_init_low,
    output dev_pin_o, dev_pin_oe_n, mgmt_rdata, tdo
  );
  modport host (
    output hard_rst_n, ref_osc_input, host_pin_o, host_pin_oe_n,
    output mgmt_clk, mgmt_wdata, tck, tms, tdi, scan_port_init_low,
    input  irq_or_sleep_pin, mgmt_rdata, tdo
  );
endinterface

// >>> logic/pcp_dev.sv
// device end: reset pin, sleep/interrupt pin, management port, test port
`timescale 1ns/100ps

// How it works
// - shared pin is sleep input after reset
// - pin low in sleep use enters sleep
// - management access keeps working while asleep
// - pending interrupt pulls shared pin low when interrupt use and interrupt enable are both set
// - interrupt use is open-drain, never drives high
// - host programs interrupt use by register first
// - hard reset returns control and status registers to defaults, not the test port
// - hard reset held low at least 1 us
// - system supplies 25 MHz reference clock
// - test clock no faster than 2.5 MHz
// - standard sixteen-state test port controller
// - shift in test data, shift out results
// - test reset clears controller asynchronously
// - test reset leaves functional registers untouched
// - management clock up to 25 MHz
module pcp_dev
  import pcp_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic event_i,
  pcp_link_if.dev   link,
  output logic      sleep_o,
  output logic      irq_mode_o,
  output logic      irq_pending_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int P_TDI  = 0;
  localparam int P_TMS  = 1;
  localparam int P_TCK  = 2;
  localparam int P_MDAT = 3;
  localparam int P_MCLK = 4;
  localparam int P_PIN  = 5;
  localparam int P_RSTN = 6;
  localparam int SN     = 7;
  localparam logic [SN-1:0] SYNC_RST = 7'h6b;

  logic [SN-1:0] raw;
  logic [SN-1:0] s1;
  logic [SN-1:0] s2;
  logic [SN-1:0] s3;
  logic [SN-1:0] lvl;
  logic [SN-1:0] rise;
  logic [SN-1:0] fall;
  logic [SN-1:0] agree;

  assign raw = {link.hard_rst_n, link.irq_or_sleep_pin, link.mgmt_clk,
                link.mgmt_wdata, link.tck, link.tms, link.tdi};
  assign agree = ~(s2 ^ s3);

  // a change counts once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1   <= SYNC_RST;
      s2   <= SYNC_RST;
      s3   <= SYNC_RST;
      lvl  <= SYNC_RST;
      rise <= '0;
      fall <= '0;
    end else begin
      s1   <= raw;
      s2   <= s1;
      s3   <= s2;
      lvl  <= (agree & s3) | (~agree & lvl);
      rise <= agree & s3 & ~lvl;
      fall <= agree & ~s3 & lvl;
    end
  end

  // ----------------------------------------
  // functional reset
  // ----------------------------------------
  logic frst;
  assign frst = sys_rst_i | ~lvl[P_RSTN];

  // ----------------------------------------
  // management receiver
  // ----------------------------------------
  logic [7:0] ctrl;
  logic       pend;
  logic       in_frame;
  logic [3:0] bit_cnt;
  logic [2:0] hdr;
  logic [6:0] wsh;
  logic [7:0] rd_sh;
  logic [2:0] next_hdr;
  logic [7:0] wr_val;
  logic       wr_go;
  logic       clr_pend;

  assign next_hdr = {hdr[1:0], lvl[P_MDAT]};
  assign wr_val   = {wsh, lvl[P_MDAT]};
  assign wr_go    = rise[P_MCLK] && in_frame && bit_cnt == MG_LAST_BIT && hdr[2];

  function automatic logic [7:0] rd_val(input logic [1:0] a);
    case (a)
      MG_ADDR_CTRL: rd_val = ctrl;
      MG_ADDR_STAT: rd_val = {6'h00, sleep_o, pend};
      default:      rd_val = 8'h00;
    endcase
  endfunction

  // runs whatever the sleep state
  always_ff @(posedge mclk_i) begin
    if (frst) begin
      in_frame <= 1'b0;
      bit_cnt  <= 4'h0;
      hdr      <= 3'h0;
      wsh      <= 7'h00;
      rd_sh    <= 8'h00;
    end else if (rise[P_MCLK]) begin
      if (!in_frame) begin
        if (!lvl[P_MDAT]) begin
          in_frame <= 1'b1;
          bit_cnt  <= 4'h1;
        end
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt < 4'(MG_HDR_BITS)) begin
          hdr <= next_hdr;
          if (bit_cnt == MG_ADDR_BIT) begin
            rd_sh <= rd_val(next_hdr[1:0]);
          end
        end else begin
          wsh   <= wr_val[6:0];
          rd_sh <= {rd_sh[6:0], 1'b0};
        end
        if (bit_cnt == MG_LAST_BIT) begin
          in_frame <= 1'b0;
        end
      end
    end
  end

  assign link.mgmt_rdata = rd_sh[7];

  // ----------------------------------------
  // control and status
  // ----------------------------------------
  assign clr_pend = wr_go && hdr[1:0] == MG_ADDR_STAT && wr_val[STAT_PEND];

  always_ff @(posedge mclk_i) begin
    if (frst) begin
      ctrl <= CTRL_RST;
    end else if (wr_go && hdr[1:0] == MG_ADDR_CTRL) begin
      ctrl <= wr_val;
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (frst) begin
      pend <= 1'b0;
    end else begin
      pend <= event_i | (pend & ~clr_pend);
    end
  end

  // ----------------------------------------
  // shared pin
  // ----------------------------------------
  logic pin_oe_n;

  always_ff @(posedge mclk_i) begin
    if (frst) begin
      pin_oe_n <= 1'b1;
      sleep_o  <= 1'b0;
    end else begin
      pin_oe_n <= ~(ctrl[CTRL_IRQ_MODE] & ctrl[CTRL_IRQ_EN] & pend);
      sleep_o  <= ~ctrl[CTRL_IRQ_MODE] & ~lvl[P_PIN];
    end
  end

  assign link.dev_pin_o    = 1'b0;
  assign link.dev_pin_oe_n = pin_oe_n;
  assign irq_mode_o        = ctrl[CTRL_IRQ_MODE];
  assign irq_pending_o     = pend;

  // ----------------------------------------
  // test access port
  // ----------------------------------------
  pcp_tap_t           tap;
  pcp_tap_t           next_tap;
  logic               tms;
  logic               tdi;
  logic [IR_W-1:0]    ir;
  logic [IR_W-1:0]    ir_sh;
  logic [DR_W-1:0]    dr_sh;
  logic               tdo;

  assign tms = lvl[P_TMS];
  assign tdi = lvl[P_TDI];

  always_comb begin
    case (tap)
      PCP_TLR:   next_tap = tms ? PCP_TLR   : PCP_RTI;
      PCP_RTI:   next_tap = tms ? PCP_SELDR : PCP_RTI;
      PCP_SELDR: next_tap = tms ? PCP_SELIR : PCP_CAPDR;
      PCP_CAPDR: next_tap = tms ? PCP_EX1DR : PCP_SHDR;
      PCP_SHDR:  next_tap = tms ? PCP_EX1DR : PCP_SHDR;
      PCP_EX1DR: next_tap = tms ? PCP_UPDR  : PCP_PSDR;
      PCP_PSDR:  next_tap = tms ? PCP_EX2DR : PCP_PSDR;
      PCP_EX2DR: next_tap = tms ? PCP_UPDR  : PCP_SHDR;
      PCP_UPDR:  next_tap = tms ? PCP_SELDR : PCP_RTI;
      PCP_SELIR: next_tap = tms ? PCP_TLR   : PCP_CAPIR;
      PCP_CAPIR: next_tap = tms ? PCP_EX1IR : PCP_SHIR;
      PCP_SHIR:  next_tap = tms ? PCP_EX1IR : PCP_SHIR;
      PCP_EX1IR: next_tap = tms ? PCP_UPIR  : PCP_PSIR;
      PCP_PSIR:  next_tap = tms ? PCP_EX2IR : PCP_PSIR;
      PCP_EX2IR: next_tap = tms ? PCP_UPIR  : PCP_SHIR;
      PCP_UPIR:  next_tap = tms ? PCP_SELDR : PCP_RTI;
      default:   next_tap = PCP_TLR;
    endcase
  end

  // test reset touches only test logic
  always_ff @(posedge mclk_i or negedge link.scan_port_init_low) begin
    if (!link.scan_port_init_low) begin
      tap <= PCP_TLR;
    end else if (sys_rst_i) begin
      tap <= PCP_TLR;
    end else if (rise[P_TCK]) begin
      tap <= next_tap;
    end
  end

  // registers shift on test clock rise, output changes on fall
  always_ff @(posedge mclk_i or negedge link.scan_port_init_low) begin
    if (!link.scan_port_init_low) begin
      ir    <= IR_IDCODE;
      ir_sh <= '0;
      dr_sh <= '0;
      tdo   <= 1'b0;
    end else if (sys_rst_i) begin
      ir    <= IR_IDCODE;
      ir_sh <= '0;
      dr_sh <= '0;
      tdo   <= 1'b0;
    end else if (rise[P_TCK]) begin
      case (tap)
        PCP_TLR:   ir    <= IR_IDCODE;
        PCP_CAPDR: dr_sh <= (ir == IR_IDCODE) ? ID_VALUE : '0;
        PCP_SHDR:  dr_sh <= (ir == IR_BYPASS) ? {31'h0, tdi}
                                               : {tdi, dr_sh[DR_W-1:1]};
        PCP_CAPIR: ir_sh <= IR_CAPTURE;
        PCP_SHIR:  ir_sh <= {tdi, ir_sh[IR_W-1:1]};
        PCP_UPIR:  ir    <= ir_sh;
        default:   ir    <= ir;
      endcase
    end else if (fall[P_TCK]) begin
      if (tap == PCP_SHDR) begin
        tdo <= dr_sh[0];
      end else if (tap == PCP_SHIR) begin
        tdo <= ir_sh[0];
      end
    end
  end

  assign link.tdo = tdo;

endmodule

// >>> logic/pcp_host.sv
// host end: reset pulse, reference clock, sleep drive, management and test master
`timescale 1ns/100ps
module pcp_host
  import pcp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       rst_req_i,
  input  wire logic       sleep_req_i,
  input  wire logic       mg_req_i,
  input  wire logic       mg_write_i,
  input  wire logic [1:0] mg_addr_i,
  input  wire logic [7:0] mg_wdata_i,
  input  wire logic       jt_req_i,
  input  wire logic       jt_tms_i,
  input  wire logic       jt_tdi_i,
  input  wire logic       jt_trst_i,
  pcp_link_if.host        link,
  output logic            rst_busy_o,
  output logic            mg_busy_o,
  output logic            mg_done_o,
  output logic [7:0]      mg_rdata_o,
  output logic            jt_busy_o,
  output logic            jt_done_o,
  output logic            jt_tdo_o,
  output logic            irq_o
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] raw, s1, s2, s3, lvl, agree;
  assign raw   = {link.tdo, link.mgmt_rdata, link.irq_or_sleep_pin};
  assign agree = ~(s2 ^ s3);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1  <= 3'h1;
      s2  <= 3'h1;
      s3  <= 3'h1;
      lvl <= 3'h1;
    end else begin
      s1  <= raw;
      s2  <= s1;
      s3  <= s2;
      lvl <= (agree & s3) | (~agree & lvl);
    end
  end
  assign irq_o = ~lvl[0];

  // ----------------------------------------
  // reference clock and hard reset
  // ----------------------------------------
  logic [7:0] ref_cnt, rst_cnt;
  logic       ref_clk, irq_shadow;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || ref_cnt == 8'(REF_HALF_CYC - 1)) begin
      ref_cnt <= 8'h00;
      ref_clk <= sys_rst_i ? 1'b0 : ~ref_clk;
    end else begin
      ref_cnt <= ref_cnt + 8'h01;
    end
  end
  assign link.ref_osc_input = ref_clk;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rst_cnt    <= 8'h00;
      rst_busy_o <= 1'b0;
    end else if (rst_req_i && !rst_busy_o) begin
      rst_cnt    <= 8'(RST_MIN_CYC - 1);
      rst_busy_o <= 1'b1;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
    end else begin
      rst_busy_o <= 1'b0;
    end
  end
  assign link.hard_rst_n = ~rst_busy_o;

  // ----------------------------------------
  // management master
  // ----------------------------------------
  logic [11:0] frame;
  logic [3:0]  mbit;
  logic [7:0]  mph;
  logic        mclk_pin;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mg_busy_o  <= 1'b0;
      mg_done_o  <= 1'b0;
      mg_rdata_o <= 8'h00;
      frame      <= 12'hfff;
      mbit       <= 4'h0;
      mph        <= 8'h00;
      mclk_pin   <= 1'b0;
    end else begin
      mg_done_o <= 1'b0;
      if (!mg_busy_o) begin
        if (mg_req_i) begin
          mg_busy_o <= 1'b1;
          frame     <= {1'b0, mg_write_i, mg_addr_i, mg_write_i ? mg_wdata_i : 8'hff};
          mbit      <= 4'h0;
          mph       <= 8'h00;
        end
      end else if (mph != 8'(MG_HALF_CYC - 1)) begin
        mph <= mph + 8'h01;
      end else begin
        mph <= 8'h00;
        if (!mclk_pin) begin
          mclk_pin <= 1'b1;
          if (mbit >= 4'(MG_HDR_BITS)) begin
            mg_rdata_o <= {mg_rdata_o[6:0], lvl[1]};
          end
        end else begin
          mclk_pin <= 1'b0;
          frame    <= {frame[10:0], 1'b1};
          if (mbit == MG_LAST_BIT) begin
            mg_busy_o <= 1'b0;
            mg_done_o <= 1'b1;
          end else begin
            mbit <= mbit + 4'h1;
          end
        end
      end
    end
  end
  assign link.mgmt_clk   = mclk_pin;
  assign link.mgmt_wdata = mg_busy_o ? frame[11] : 1'b1;

  // interrupt use only after programming; hard reset undoes it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || rst_busy_o) begin
      irq_shadow <= 1'b0;
    end else if (mg_req_i && !mg_busy_o && mg_write_i && mg_addr_i == MG_ADDR_CTRL) begin
      irq_shadow <= mg_wdata_i[CTRL_IRQ_MODE];
    end
  end
  assign link.host_pin_o    = 1'b0;
  assign link.host_pin_oe_n = ~(sleep_req_i & ~irq_shadow);

  // ----------------------------------------
  // test port master, one test clock per request
  // ----------------------------------------
  logic [7:0] jph;
  logic       tck, tms, tdi, trst_n;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      jt_busy_o <= 1'b0;
      jt_done_o <= 1'b0;
      jt_tdo_o  <= 1'b0;
      jph       <= 8'h00;
      tck       <= 1'b0;
      tms       <= 1'b1;
      tdi       <= 1'b1;
      trst_n    <= 1'b1;
    end else begin
      jt_done_o <= 1'b0;
      trst_n    <= ~jt_trst_i;
      if (!jt_busy_o) begin
        if (jt_req_i) begin
          jt_busy_o <= 1'b1;
          tms       <= jt_tms_i;
          tdi       <= jt_tdi_i;
          jph       <= 8'h00;
        end
      end else if (jph != 8'(TCK_HALF_CYC - 1)) begin
        jph <= jph + 8'h01;
      end else begin
        jph <= 8'h00;
        if (!tck) begin
          tck      <= 1'b1;
          jt_tdo_o <= lvl[2];
        end else begin
          tck       <= 1'b0;
          jt_busy_o <= 1'b0;
          jt_done_o <= 1'b1;
        end
      end
    end
  end
  assign link.tck                = tck;
  assign link.tms                = tms;
  assign link.tdi                = tdi;
  assign link.scan_port_init_low = trst_n;

endmodule

// >>> test/pcp_props.sv
// assertions on the control-pin link between the host and device ends
`timescale 1ns/100ps
module pcp_props
  import pcp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic hard_rst_n,
  input wire logic host_pin_o,
  input wire logic host_pin_oe_n,
  input wire logic dev_pin_o,
  input wire logic dev_pin_oe_n,
  input wire logic irq_or_sleep_pin,
  input wire logic mgmt_clk,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic scan_port_init_low
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // cycle counters for pulse widths
  // ----------------------------------------
  logic        tck_q;
  logic        mg_q;
  logic [11:0] tck_cnt;
  logic [11:0] mg_cnt;
  logic [11:0] rlo_cnt;

  always_ff @(posedge mclk_i) begin
    tck_q   <= sys_rst_i ? 1'b0 : tck;
    tck_cnt <= (sys_rst_i || tck != tck_q) ? 12'h001 : tck_cnt + {11'h000, ~&tck_cnt};
  end
  always_ff @(posedge mclk_i) begin
    mg_q   <= sys_rst_i ? 1'b0 : mgmt_clk;
    mg_cnt <= (sys_rst_i || mgmt_clk != mg_q) ? 12'h001 : mg_cnt + {11'h000, ~&mg_cnt};
  end
  always_ff @(posedge mclk_i) begin
    rlo_cnt <= (sys_rst_i || hard_rst_n) ? 12'h000 : rlo_cnt + {11'h000, ~&rlo_cnt};
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_dev_open_drain: assert property (!dev_pin_oe_n |-> !dev_pin_o)
    else $error("device drives the shared pin high");
  a_host_open_drain: assert property (!host_pin_oe_n |-> !host_pin_o)
    else $error("host drives the shared pin high");
  a_pull_wins: assert property (!dev_pin_oe_n |-> !irq_or_sleep_pin)
    else $error("shared pin high while device pulls");
  a_rst_width: assert property ($rose(hard_rst_n) |-> rlo_cnt >= RST_MIN_CYC - 1)
    else $error("hard reset pulse too short");
  a_rst_release: assert property (!hard_rst_n [*8] |-> dev_pin_oe_n)
    else $error("shared pin still pulled in hard reset");
  a_tck_half: assert property ((tck != tck_q) |-> tck_cnt >= TCK_HALF_CYC - 1)
    else $error("test clock phase too short");
  a_mg_half: assert property ((mgmt_clk != mg_q) |-> mg_cnt >= MG_HALF_CYC - 1)
    else $error("management clock phase too short");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
    else $error("test output moved while test clock high");
  a_tms_hold: assert property (tck |-> $stable(tms) && $stable(tdi))
    else $error("mode or data input moved while test clock high");
  a_trst_clears: assert property (!scan_port_init_low |-> !tdo)
    else $error("test output not cleared by test reset");
endmodule

// >>> test/phy_reset_powerdown_test_port_tb_top.sv
// self-checking bench joining the host and device ends over the link
`timescale 1ns/100ps
module phy_reset_powerdown_test_port_tb_top
  import pcp_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        event_i = 1'b0;
  logic        rst_req_i = 1'b0;
  logic        sleep_req_i = 1'b0;
  logic        mg_req_i = 1'b0;
  logic        mg_write_i = 1'b0;
  logic [1:0]  mg_addr_i = 2'h0;
  logic [7:0]  mg_wdata_i = 8'h00;
  logic        jt_req_i = 1'b0;
  logic        jt_tms_i = 1'b1;
  logic        jt_tdi_i = 1'b1;
  logic        jt_trst_i = 1'b0;
  logic        sleep_o, irq_mode_o, irq_pending_o, rst_busy_o, mg_busy_o, mg_done_o;
  logic        jt_busy_o, jt_done_o, jt_tdo_o, irq_o;
  logic [7:0]  mg_rdata_o;
  logic [11:0] frm = 12'h000;
  logic [31:0] dv;
  int          errors = 0;
  int          compares = 0;
  int          n;

  always #2 mclk_i = ~mclk_i;

  pcp_link_if lnk ();

  pcp_dev u_pcp_dev (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .event_i(event_i), .link(lnk.dev),
    .sleep_o(sleep_o), .irq_mode_o(irq_mode_o), .irq_pending_o(irq_pending_o)
  );
  pcp_host u_pcp_host (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rst_req_i(rst_req_i),
    .sleep_req_i(sleep_req_i), .mg_req_i(mg_req_i), .mg_write_i(mg_write_i),
    .mg_addr_i(mg_addr_i), .mg_wdata_i(mg_wdata_i), .jt_req_i(jt_req_i),
    .jt_tms_i(jt_tms_i), .jt_tdi_i(jt_tdi_i), .jt_trst_i(jt_trst_i), .link(lnk.host),
    .rst_busy_o(rst_busy_o), .mg_busy_o(mg_busy_o), .mg_done_o(mg_done_o),
    .mg_rdata_o(mg_rdata_o), .jt_busy_o(jt_busy_o), .jt_done_o(jt_done_o),
    .jt_tdo_o(jt_tdo_o), .irq_o(irq_o)
  );
  pcp_props u_pcp_props (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hard_rst_n(lnk.hard_rst_n),
    .host_pin_o(lnk.host_pin_o), .host_pin_oe_n(lnk.host_pin_oe_n),
    .dev_pin_o(lnk.dev_pin_o), .dev_pin_oe_n(lnk.dev_pin_oe_n),
    .irq_or_sleep_pin(lnk.irq_or_sleep_pin), .mgmt_clk(lnk.mgmt_clk), .tck(lnk.tck),
    .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .scan_port_init_low(lnk.scan_port_init_low)
  );

  // last twelve management bits as seen on the wire
  always @(posedge lnk.mgmt_clk) frm <= {frm[10:0], lnk.mgmt_wdata};

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic clk(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse_event;
    event_i = 1'b1;
    clk(1);
    event_i = 1'b0;
    clk(8);
  endtask
  task automatic mg_op(input logic w, input logic [1:0] a, input logic [7:0] d);
    mg_req_i   = 1'b1;
    mg_write_i = w;
    mg_addr_i  = a;
    mg_wdata_i = d;
    clk(1);
    mg_req_i = 1'b0;
    for (n = 0; n < 400 && mg_done_o !== 1'b1; n++) clk(1);
    if (mg_done_o !== 1'b1) begin
      errors++;
      $display("[ERR] %0t management frame timed out", $time);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    mg_op(1'b0, a, 8'hff);
    chk_vec({24'h0, mg_rdata_o}, {24'h0, exp});
    chk_bit(mg_busy_o, 1'b0);
  endtask
  task automatic jt_step(input logic ms, input logic di);
    jt_req_i = 1'b1;
    jt_tms_i = ms;
    jt_tdi_i = di;
    clk(1);
    jt_req_i = 1'b0;
    for (n = 0; n < 300 && jt_done_o !== 1'b1; n++) clk(1);
    if (jt_done_o !== 1'b1) begin
      errors++;
      $display("[ERR] %0t test clock step timed out", $time);
    end
  endtask
  task automatic nav(input int c, input logic [7:0] ms);
    for (int k = 0; k < c; k++) jt_step(ms[k], 1'b1);
  endtask
  task automatic scan(input int c, input logic [31:0] din);
    dv = 32'h0;
    for (int k = 0; k < c; k++) begin
      jt_step(k == c - 1, din[k]);
      dv[k] = jt_tdo_o;
    end
    chk_bit(jt_busy_o, 1'b0);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    clk(16);
    sys_rst_i = 1'b0;
    clk(1);
    chk_bit(lnk.irq_or_sleep_pin, 1'b1);
    rd(MG_ADDR_CTRL, CTRL_RST);
    chk_vec({20'h0, frm}, 32'h0ff);
    chk_bit(irq_mode_o, 1'b0);
    dv[0] = lnk.ref_osc_input;
    clk(REF_HALF_CYC);
    chk_bit(lnk.ref_osc_input, ~dv[0]);
    sleep_req_i = 1'b1;
    clk(12);
    chk_bit(sleep_o, 1'b1);
    mg_op(1'b1, MG_ADDR_CTRL, 8'h02);
    rd(MG_ADDR_CTRL, 8'h02);
    rd(MG_ADDR_STAT, 8'h02);
    sleep_req_i = 1'b0;
    clk(12);
    chk_bit(sleep_o, 1'b0);
    pulse_event;
    chk_bit(irq_o, 1'b0);
    mg_op(1'b1, MG_ADDR_STAT, 8'h01);
    mg_op(1'b1, MG_ADDR_CTRL, 8'h03);
    chk_vec({20'h0, frm}, 32'h403);
    chk_bit(irq_mode_o, 1'b1);
    clk(8);
    chk_bit(irq_o, 1'b0);
    pulse_event;
    chk_bit(irq_o, 1'b1);
    chk_bit(lnk.dev_pin_oe_n, 1'b0);
    chk_bit(sleep_o, 1'b0);
    rd(MG_ADDR_STAT, 8'h01);
    mg_op(1'b1, 2'h2, 8'hff);
    rd(2'h2, 8'h00);
    jt_trst_i = 1'b1;
    clk(4);
    chk_bit(lnk.tdo, 1'b0);
    jt_trst_i = 1'b0;
    clk(1);
    rd(MG_ADDR_CTRL, 8'h03);
    chk_bit(irq_pending_o, 1'b1);
    rst_req_i = 1'b1;
    clk(1);
    rst_req_i = 1'b0;
    clk(2);
    for (n = 0; n < 400 && rst_busy_o === 1'b1; n++) clk(1);
    chk_bit(rst_busy_o, 1'b0);
    clk(8);
    chk_bit(irq_pending_o, 1'b0);
    chk_bit(irq_mode_o, 1'b0);
    chk_bit(irq_o, 1'b0);
    rd(MG_ADDR_CTRL, CTRL_RST);
    nav(4, 8'h02);
    scan(32, 32'hffff_ffff);
    chk_vec(dv, ID_VALUE);
    nav(2, 8'h01);
    nav(4, 8'h03);
    scan(2, {30'h0, IR_BYPASS});
    chk_vec(dv, {30'h0, IR_CAPTURE});
    nav(2, 8'h01);
    nav(3, 8'h01);
    scan(4, 32'hb);
    chk_vec(dv, 32'h6);
    nav(2, 8'h01);
    jt_trst_i = 1'b1;
    clk(4);
    jt_trst_i = 1'b0;
    clk(1);
    nav(4, 8'h02);
    scan(32, 32'h0);
    chk_vec(dv, ID_VALUE);
    end_sim;
  end

  // cut a hang short well past the expected run of about 11000 cycles
  initial begin
    repeat (40000) @(posedge mclk_i);
    errors++;
    end_sim;
  end
endmodule
